// ===== include/msg_port_pkg.sv
// Constants used by the message stream port; its pin synchroniser uses none of them.
// Behaviour
// - Slave only, master clock at most 400 kHz.
// - Address setting: upper seven bits are address.
// - Eight-bit index selects one of 256 bytes.
// - Indices 0x00 to 0xFC read undefined.
// - Indices pending_count_high, pending_count_low return waiting byte count.
// - Stream index reads 0xFF when queue empty.
// - Stream index pops next waiting byte in order.
// - Address with write bit acknowledged when matching.
// - Index write, repeated start, read, nack, stop.
// - Current read uses pointer, increments, holds at top.
// - Pointer starts at message_stream_out after reset.
// - Registers unwritable; written bytes go to parser.
// - Message needs two bytes; one byte sets pointer.
package msg_port_pkg;

  // Clock and bus rates.
  localparam int CLK_HZ = 200000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int SCL_MIN_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ;

  // Register indices.
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hFD;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hFE;
  localparam logic [7:0] IDX_STREAM = 8'hFF;
  localparam logic [7:0] PTR_RESET = 8'hFF;

  // Values returned by reads.
  localparam logic [7:0] EMPTY_VALUE = 8'hFF;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;

  // Bit counting and address field layout.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RW_BIT = 0;

  // Write byte counter values.
  localparam logic [1:0] WR_NONE = 2'h0;
  localparam logic [1:0] WR_ONE = 2'h1;
  localparam logic [1:0] WR_MANY = 2'h2;

  // Protocol engine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } state_t;

endpackage

// ===== hw/pin_sync.sv
// Three-stage synchroniser that accepts a level once two stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Pin and its settled level.
  input wire logic i_pin,
  output logic o_level
);

  logic ff1_q, ff2_q, ff3_q, level_q;
  logic level_d;

  // The settled level moves only when stages two and three agree.
  always_comb begin
    level_d = level_q;
    if (ff2_q == ff3_q) begin
      level_d = ff3_q;
    end
  end

  // Registers; the bus idles high so that is the reset value.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ff1_q <= 1'b1;
      ff2_q <= 1'b1;
      ff3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      ff1_q <= i_pin;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule
`default_nettype wire

// ===== hw/msg_stream_i2c_slave.sv
// Fast-mode I2C slave giving the host the outgoing message stream.
`timescale 1ns/1ps
`default_nettype none
module msg_stream_i2c_slave (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Serial bus pins; the data line is open drain.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Configured slave address setting.
  input wire logic [7:0] i_slave_addr,
  // Outgoing message queue.
  input wire logic [15:0] i_tx_count,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_pop,
  // Incoming message bytes towards the parser.
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_last,
  // Current register pointer.
  output logic [7:0] o_pointer
);

  logic scl, sda, scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  msg_port_pkg::state_t state_q, state_d;
  logic [7:0] shreg_q, shreg_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] hold_q, hold_d;
  logic [1:0] wr_cnt_q, wr_cnt_d;
  logic sda_low_q, sda_low_d;
  logic ack_q, ack_d;
  logic pop_d, pop_q;
  logic [7:0] rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d, rx_last_q, rx_last_d;

  // Both pins are asynchronous to the core clock; at 200 MHz a 400 kHz
  // clock gives hundreds of samples per bit, so plain edge detection works.
  pin_sync scl_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_pin(i_scl),
    .o_level(scl)
  );
  pin_sync sda_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_pin(i_sda),
    .o_level(sda)
  );

  // Bus events from the settled levels.
  assign scl_rise = scl & ~scl_prev_q;
  assign scl_fall = ~scl & scl_prev_q;
  assign start_cond = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop_cond = scl & scl_prev_q & ~sda_prev_q & sda;

  // Byte that a read of the given index returns.
  function automatic logic [7:0] read_value(input logic [7:0] idx,
                                            input logic [15:0] cnt,
                                            input logic valid,
                                            input logic [7:0] data);
    logic [7:0] v;
    v = msg_port_pkg::RESERVED_VALUE;
    if (idx == msg_port_pkg::IDX_COUNT_HIGH) begin
      v = cnt[15:8];
    end else if (idx == msg_port_pkg::IDX_COUNT_LOW) begin
      v = cnt[7:0];
    end else if (idx == msg_port_pkg::IDX_STREAM) begin
      v = valid ? data : msg_port_pkg::EMPTY_VALUE;
    end
    return v;
  endfunction

  // Protocol engine: next-state and datapath.
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    bit_cnt_d = bit_cnt_q;
    ptr_d = ptr_q;
    hold_d = hold_q;
    wr_cnt_d = wr_cnt_q;
    sda_low_d = sda_low_q;
    ack_d = ack_q;
    pop_d = 1'b0;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    rx_last_d = 1'b0;
    if (start_cond || stop_cond) begin
      // A lone written byte only moves the pointer; a longer write
      // releases its final held byte as the end of the message.
      if (wr_cnt_q == msg_port_pkg::WR_ONE) begin
        ptr_d = hold_q;
      end else if (wr_cnt_q == msg_port_pkg::WR_MANY) begin
        rx_data_d = hold_q;
        rx_valid_d = 1'b1;
        rx_last_d = 1'b1;
      end
      wr_cnt_d = msg_port_pkg::WR_NONE;
      sda_low_d = 1'b0;
      bit_cnt_d = '0;
      state_d = start_cond ? msg_port_pkg::ST_ADDR : msg_port_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        msg_port_pkg::ST_IDLE: begin
          sda_low_d = 1'b0;
        end
        msg_port_pkg::ST_ADDR, msg_port_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            shreg_d = {shreg_q[6:0], sda};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall &&
                       bit_cnt_q == msg_port_pkg::BITS_PER_BYTE) begin
            bit_cnt_d = '0;
            if (state_q == msg_port_pkg::ST_ADDR) begin
              if (shreg_q[msg_port_pkg::ADDR_MSB:msg_port_pkg::ADDR_LSB] ==
                  i_slave_addr[msg_port_pkg::ADDR_MSB:
                               msg_port_pkg::ADDR_LSB]) begin
                sda_low_d = 1'b1;
                state_d = msg_port_pkg::ST_ADDR_ACK;
              end else begin
                state_d = msg_port_pkg::ST_IDLE;
              end
            end else begin
              // Written bytes never land in a register; each is held
              // one byte deep so a single-byte write is recognised.
              if (wr_cnt_q != msg_port_pkg::WR_NONE) begin
                rx_data_d = hold_q;
                rx_valid_d = 1'b1;
              end
              hold_d = shreg_q;
              if (wr_cnt_q != msg_port_pkg::WR_MANY) begin
                wr_cnt_d = wr_cnt_q + 2'h1;
              end
              sda_low_d = 1'b1;
              state_d = msg_port_pkg::ST_WR_ACK;
            end
          end
        end
        msg_port_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shreg_q[msg_port_pkg::RW_BIT]) begin
              // Load first read byte and move the pointer on unless it sits at the stream index.
              shreg_d = read_value(ptr_q, i_tx_count, i_tx_valid,
                                   i_tx_data);
              pop_d = (ptr_q == msg_port_pkg::IDX_STREAM) & i_tx_valid;
              if (ptr_q != msg_port_pkg::IDX_STREAM) begin
                ptr_d = ptr_q + 8'h01;
              end
              sda_low_d = ~shreg_d[7];
              state_d = msg_port_pkg::ST_RD_BYTE;
            end else begin
              sda_low_d = 1'b0;
              state_d = msg_port_pkg::ST_WR_BYTE;
            end
          end
        end
        msg_port_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            sda_low_d = 1'b0;
            state_d = msg_port_pkg::ST_WR_BYTE;
          end
        end
        msg_port_pkg::ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_q == msg_port_pkg::LAST_READ_BIT) begin
              sda_low_d = 1'b0;
              bit_cnt_d = '0;
              state_d = msg_port_pkg::ST_RD_ACK;
            end else begin
              shreg_d = {shreg_q[6:0], 1'b0};
              sda_low_d = ~shreg_q[6];
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        msg_port_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            ack_d = ~sda;
          end else if (scl_fall) begin
            if (ack_q) begin
              shreg_d = read_value(ptr_q, i_tx_count, i_tx_valid,
                                   i_tx_data);
              pop_d = (ptr_q == msg_port_pkg::IDX_STREAM) & i_tx_valid;
              if (ptr_q != msg_port_pkg::IDX_STREAM) begin
                ptr_d = ptr_q + 8'h01;
              end
              sda_low_d = ~shreg_d[7];
              state_d = msg_port_pkg::ST_RD_BYTE;
            end else begin
              state_d = msg_port_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_d = msg_port_pkg::ST_IDLE;
          sda_low_d = 1'b0;
        end
      endcase
    end
  end

  // Protocol engine registers.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      state_q <= msg_port_pkg::ST_IDLE;
      shreg_q <= '0;
      bit_cnt_q <= '0;
      ptr_q <= msg_port_pkg::PTR_RESET;
      hold_q <= '0;
      wr_cnt_q <= msg_port_pkg::WR_NONE;
      sda_low_q <= 1'b0;
      ack_q <= 1'b0;
      pop_q <= 1'b0;
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      rx_last_q <= 1'b0;
    end else begin
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      state_q <= state_d;
      shreg_q <= shreg_d;
      bit_cnt_q <= bit_cnt_d;
      ptr_q <= ptr_d;
      hold_q <= hold_d;
      wr_cnt_q <= wr_cnt_d;
      sda_low_q <= sda_low_d;
      ack_q <= ack_d;
      pop_q <= pop_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      rx_last_q <= rx_last_d;
    end
  end

  // Outputs; the data line is only ever pulled low.
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_low_q;
  assign o_tx_pop = pop_q;
  assign o_rx_data = rx_data_q;
  assign o_rx_valid = rx_valid_q;
  assign o_rx_last = rx_last_q;
  assign o_pointer = ptr_q;

endmodule
`default_nettype wire

// ===== tb/msg_stream_i2c_slave_sva.sv
// Checker bound to the message stream port.
`timescale 1ns/1ps
`default_nettype none
module msg_stream_i2c_slave_sva (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Watched pins.
  input wire logic i_scl,
  input wire logic i_tx_valid,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_tx_pop,
  input wire logic o_rx_valid,
  input wire logic o_rx_last,
  input wire logic [7:0] o_pointer
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // The data pin is open drain and only ever pulled low.
  property p_low; o_sda_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("data driven high");
  // The pointer comes out of reset at the top index with the pin released.
  property p_ptr0;
    $fell(i_reset) |-> o_pointer == 8'hFF && !o_sda_oe;
  endproperty
  a_ptr0: assert property (p_ptr0) else $error("bad reset");
  // A stream byte is only taken while the pointer sits at the top.
  property p_top; o_tx_pop |-> o_pointer == 8'hFF; endproperty
  a_top: assert property (p_top) else $error("pop off top");
  property p_once; o_tx_pop |=> !o_tx_pop; endproperty
  a_once: assert property (p_once) else $error("double pop");
  property p_pv; o_tx_pop |-> $past(i_tx_valid); endproperty
  a_pv: assert property (p_pv) else $error("pop when empty");
  // Message bytes are single pulses and the end mark rides with one.
  property p_last; o_rx_last |-> o_rx_valid; endproperty
  a_last: assert property (p_last) else $error("lone last");
  property p_rx1; o_rx_valid |=> !o_rx_valid; endproperty
  a_rx1: assert property (p_rx1) else $error("long rx pulse");
  // The slave moves the data pin only while the bus clock is low.
  property p_oe;
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("data moved on high");
endmodule
bind msg_stream_i2c_slave msg_stream_i2c_slave_sva sva_inst (
  .i_clk_sys, .i_reset, .i_scl, .i_tx_valid, .o_sda_out, .o_sda_oe,
  .o_tx_pop, .o_rx_valid, .o_rx_last, .o_pointer);
`default_nettype wire

// ===== tb/i2c_host_model.sv
// Bus master model that clocks bytes to and from the port.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Clock and resolved data line.
  input wire logic i_clk_sys,
  input wire logic i_sda,
  // Bus clock and data pull-down.
  output logic o_scl,
  output logic o_sda_low
);
  localparam int HALF = 250; // 250 cycles a phase is 400 kHz.
  // Bus idles high through the pull-ups.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Waits one clock phase.
  task automatic wt();
    repeat (HALF) @(posedge i_clk_sys);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    o_sda_low <= 1'b0;
    wt();
    o_scl <= 1'b1;
    wt();
    o_sda_low <= 1'b1;
    wt();
    o_scl <= 1'b0;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    o_sda_low <= 1'b1;
    wt();
    o_scl <= 1'b1;
    wt();
    o_sda_low <= 1'b0;
    wt();
  endtask
  // Drives one bit and samples the line in mid high phase.
  task automatic bit_io(input logic b, output logic s);
    o_sda_low <= !b;
    wt();
    o_scl <= 1'b1;
    repeat (HALF / 2) @(posedge i_clk_sys);
    s = i_sda;
    repeat (HALF / 2) @(posedge i_clk_sys);
    o_scl <= 1'b0;
  endtask
  // Moves a byte MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] tx, input logic ai,
                      output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ai, ao);
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Bench that plays bus transfers against the message stream port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic scl, sda_low, sda, sda_out, sda_oe, pop, rx_valid, rx_last, ack;
  logic [7:0] rx_data, ptr, got;
  logic [7:0] addr = 8'h85;
  logic [8:0] rxq[$];
  logic [7:0] qd[3] = '{8'hA5, 8'h3C, 8'h5A};
  int head = 0;
  int cyc = 0;
  int err_count = 0;
  int num_checks = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  // Open-drain data line with a pull-up; either side pulling low drives it low.
  assign sda = !(sda_low || (sda_oe && !sda_out));
  i2c_host_model host (.i_clk_sys, .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  msg_stream_i2c_slave msg_stream_i2c_slave_inst (.i_clk_sys, .i_reset,
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_slave_addr(addr), .i_tx_count(16'(3 - head)),
    .i_tx_valid(head < 3), .i_tx_data(head < 3 ? qd[head] : 8'h00),
    .o_tx_pop(pop), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_rx_last(rx_last), .o_pointer(ptr));
  // Queue advances on pops, message bytes are logged, hangs are cut.
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (pop === 1'b1 && head < 3)
      head <= head + 1;
    if (rx_valid === 1'b1)
      rxq.push_back({rx_last, rx_data});
    if (cyc == 95000) begin
      err_count++;
      wrap_up();
    end
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Byte write and byte read with master acknowledge or not.
  task automatic wr(input logic [7:0] b);
    host.xfer(b, 1'b1, got, ack);
  endtask
  task automatic rd(input logic nack);
    host.xfer(8'hFF, nack, got, ack);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence of transfers.
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    chk("pointer reset", 9'h0FF, ptr);
    host.start();
    wr(8'h86);
    chk("foreign ack", 9'h001, ack);
    host.stop();
    $display("test foreign address done");
    host.start();
    wr(8'h84);
    chk("addr ack", 9'h000, ack);
    wr(8'hFC);
    chk("index ack", 9'h000, ack);
    host.start();
    wr(8'h85);
    chk("read ack", 9'h000, ack);
    rd(1'b0);
    chk("reserved", 9'h000, got);
    rd(1'b0);
    chk("count high", 9'h000, got);
    rd(1'b0);
    chk("count low", 9'h003, got);
    rd(1'b1);
    chk("stream head", 9'h0A5, got);
    host.stop();
    chk("pointer top", 9'h0FF, ptr);
    chk("no message", 9'h000, 9'(rxq.size()));
    $display("test random read done");
    // Past the reserved probe and the two count reads the host keeps to the stream index.
    host.start();
    wr(8'h85);
    chk("current ack", 9'h000, ack);
    rd(1'b0);
    chk("stream next", 9'h03C, got);
    rd(1'b0);
    chk("stream last", 9'h05A, got);
    rd(1'b1);
    chk("stream empty", 9'h0FF, got);
    host.stop();
    chk("pointer held", 9'h0FF, ptr);
    chk("pops", 9'h003, 9'(head));
    $display("test current read done");
    host.start();
    wr(8'h84);
    wr(8'h11);
    wr(8'h22);
    chk("data ack", 9'h000, ack);
    host.stop();
    chk("message count", 9'h002, 9'(rxq.size()));
    chk("first byte", 9'h011, rxq[0]);
    chk("last byte", 9'h122, rxq[1]);
    chk("pointer kept", 9'h0FF, ptr);
    $display("test message write done");
    wrap_up();
  end
endmodule
`default_nettype wire
